// [ism_defines.svh]
// timing constants and bus codes for the serial memory master
`ifndef ISM_DEFINES_SVH
`define ISM_DEFINES_SVH
`define ISM_CLK_HZ 250000000
`define ISM_STD_HZ 100000
`define ISM_FAST_HZ 400000
// quarter-bit enable period in clk_sys cycles (rounded up so the bus never runs fast)
`define ISM_STD_QTR ((`ISM_CLK_HZ + 4 * `ISM_STD_HZ - 1) / (4 * `ISM_STD_HZ))
`define ISM_FAST_QTR ((`ISM_CLK_HZ + 4 * `ISM_FAST_HZ - 1) / (4 * `ISM_FAST_HZ))
`define ISM_RW_WRITE 1'b0
`define ISM_RW_READ 1'b1
`endif

// [ism_pkg.sv]
// types for the serial memory master
package ism_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_START = 4'h1,
      ST_DEVADR = 4'h2,
      ST_BYTADR = 4'h3,
      ST_RESTART = 4'h4,
      ST_DEVRD = 4'h5,
      ST_WRDATA = 4'h6,
      ST_RDDATA = 4'h7,
      ST_STOP = 4'h8
   } ism_state_e;
endpackage

// [ism_qtr_tick.sv]
// quarter-bit enable divider with standard and fast rates
`timescale 1ns/1ps
`default_nettype none
`include "ism_defines.svh"
module ism_qtr_tick
   import ism_pkg::*;
#(
   parameter int STD_QTR = `ISM_STD_QTR,
   parameter int FAST_QTR = `ISM_FAST_QTR
)(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic run,
   input wire logic fastMode,
   output logic tick
);
   initial begin
      if (STD_QTR < 2 || FAST_QTR < 2 || STD_QTR > 65535 || FAST_QTR > 65535)
         $error("ism_qtr_tick: divider out of range");
   end
   logic [15:0] cnt_q;
   logic [15:0] lim;
   // rate selection between the two bus modes
   assign lim = fastMode ? 16'(FAST_QTR - 1) : 16'(STD_QTR - 1); // [RQ9]
   // count up one quarter bit, pulse at wrap
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_q <= 16'h0000;
         tick <= 1'b0;
      end
      else if (!run)
      begin
         cnt_q <= 16'h0000;
         tick <= 1'b0;
      end
      else if (cnt_q >= lim)
      begin
         cnt_q <= 16'h0000;
         tick <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule // ism_qtr_tick
`default_nettype wire

// [ism_sync2.sv]
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module ism_sync2 (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic pinIn,
   output logic pinSync
);
   logic meta_q;
   // idle bus level is high
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_q <= 1'b1;
         pinSync <= 1'b1;
      end
      else
      begin
         meta_q <= pinIn;
         pinSync <= meta_q;
      end
   end
endmodule // ism_sync2
`default_nettype wire

// [ism_master.sv]
// two-wire bus master for a serial memory: start, addresses, data bytes, stop
// Notes on behaviour
// [RQ1] every transfer opens with a start condition before any bit goes out.
// [RQ2] the 7-bit device address is sent first, then an 8-bit byte address.
// [RQ3] all bytes are shifted most significant bit first.
// [RQ4] on a read the master drives an acknowledge bit after each received byte.
// [RQ5] on a write the memory answers each byte and the master samples that bit.
// [RQ6] one transfer carries one byte or a run of several bytes either way.
// [RQ7] when all bytes are handled the master ends with a stop condition.
// [RQ8] the last read byte gets a not-acknowledge, earlier ones an acknowledge.
// [RQ9] bus clock is selectable between standard and fast rate.
// [RQ10] outputs are open-drain or push-pull by a mode input; the code switches only the clock output, sda stays open-drain.
// [RQ11] in push-pull the clock line is driven both ways, data stays open-drain.
// [RQ12] only 7-bit device addressing exists.
// [RQ13] the device and byte address come from the user to match the attached memory.
// [RQ14] a read sends the byte address, then a repeated start and the address with read set.
`timescale 1ns/1ps
`default_nettype none
`include "ism_defines.svh"
module ism_master
   import ism_pkg::*;
#(
   parameter int STD_QTR = `ISM_STD_QTR,
   parameter int FAST_QTR = `ISM_FAST_QTR
)(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic fastMode,
   input wire logic pushPull,
   input wire logic reqValid,
   output logic reqReady,
   input wire logic reqRead,
   input wire logic [6:0] devAddr,
   input wire logic [7:0] byteAddr,
   input wire logic wrValid,
   output logic wrReady,
   input wire logic [7:0] wrData,
   input wire logic wrLast,
   input wire logic rdLast,
   output logic rdValid,
   output logic [7:0] rdData,
   output logic done,
   output logic nackErr,
   output logic busy,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOen,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOen
);
   ism_state_e st_q;
   logic tick;
   logic sdaSync;
   logic sclSync;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [8:0] sh_q;
   logic rd_q;
   logic lastRd_q;
   logic sclDrv_q;
   logic sdaDrv_q;
   logic [6:0] dev_q;
   logic [7:0] badr_q;
   logic err_q;
   logic byteSt;
   logic bitEnd;
   // bus pins pass two flip-flops
   ism_sync2 u_sda (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pinIn(sdaIn),
      .pinSync(sdaSync)
   );
   ism_sync2 u_scl (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pinIn(sclIn),
      .pinSync(sclSync)
   );
   ism_qtr_tick #(
      .STD_QTR(STD_QTR),
      .FAST_QTR(FAST_QTR)
   ) u_tick (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .run(st_q != ST_IDLE),
      .fastMode(fastMode),
      .tick(tick)
   );
   // byte-shifting states and end of a bit slot
   assign byteSt = (st_q == ST_DEVADR) || (st_q == ST_BYTADR) || (st_q == ST_DEVRD)
                   || (st_q == ST_WRDATA) || (st_q == ST_RDDATA);
   assign bitEnd = tick && (ph_q == 2'd3);
   assign busy = (st_q != ST_IDLE);
   assign reqReady = (st_q == ST_IDLE);
   // next write byte is taken at the end of the ack slot
   assign wrReady = bitEnd && (bit_q == 4'd8) && !rd_q && !err_q
                    && ((st_q == ST_BYTADR) || (st_q == ST_WRDATA && !lastRd_q));
   // clock line: open-drain releases high, push-pull drives both levels
   assign sclOut = pushPull ? sclDrv_q : 1'b0; // [RQ10]
   assign sclOen = pushPull ? 1'b0 : sclDrv_q; // [RQ11]
   // data line is shared, so it is only ever pulled low
   assign sdaOut = 1'b0; // [RQ11]
   assign sdaOen = sdaDrv_q;
   // phase and bit counters, advance on quarter-bit ticks; clock stretching holds phase 2
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         ph_q <= 2'd0;
         bit_q <= 4'd0;
      end
      else if (st_q == ST_IDLE)
      begin
         ph_q <= 2'd0;
         bit_q <= 4'd0;
      end
      else if (tick && !(ph_q == 2'd2 && !sclSync))
      begin
         ph_q <= ph_q + 2'd1;
         if (bitEnd)
            bit_q <= (!byteSt || bit_q == 4'd8) ? 4'd0 : bit_q + 4'd1;
      end
   end
   // line drive per phase: clock low in 0 and 1, high in 2 and 3; data moves entering phase 1
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         sclDrv_q <= 1'b1;
         sdaDrv_q <= 1'b1;
      end
      else if (tick)
      begin
         case (st_q)
            ST_START, ST_RESTART:
            begin
               // data falls while clock high
               sclDrv_q <= (ph_q != 2'd3);
               if (ph_q == 2'd0)
                  sdaDrv_q <= 1'b1;
               else if (ph_q == 2'd2)
                  sdaDrv_q <= 1'b0; // [RQ1] [RQ14]
            end
            ST_STOP:
            begin
               // data rises while clock high
               sclDrv_q <= (ph_q != 2'd0);
               if (ph_q == 2'd0)
                  sdaDrv_q <= 1'b0;
               else if (ph_q == 2'd2)
                  sdaDrv_q <= 1'b1; // [RQ7]
            end
            ST_IDLE:
            begin
               sclDrv_q <= 1'b1;
               sdaDrv_q <= 1'b1;
            end
            default:
            begin
               sclDrv_q <= (ph_q == 2'd1) || (ph_q == 2'd2);
               if (ph_q == 2'd0)
                  sdaDrv_q <= sh_q[8]; // [RQ3]
            end
         endcase
      end
   end
   // shift register: msb leaves at bit 8, ones enter at bit 0; read bits shift into rdData instead
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         sh_q <= 9'h1FF;
         rdData <= 8'h00;
         rdValid <= 1'b0;
      end
      else
      begin
         rdValid <= 1'b0;
         if (st_q == ST_START && bitEnd)
            sh_q <= {dev_q, `ISM_RW_WRITE, 1'b1}; // [RQ2] [RQ12]
         else if (st_q == ST_RESTART && bitEnd)
            sh_q <= {dev_q, `ISM_RW_READ, 1'b1}; // [RQ14]
         else if (byteSt && bitEnd && bit_q == 4'd8)
         begin
            if (st_q == ST_DEVADR)
               sh_q <= {badr_q, 1'b1}; // [RQ2]
            else if (st_q == ST_RDDATA || st_q == ST_DEVRD)
               sh_q <= 9'h1FF;
            else
               sh_q <= {wrData, 1'b1};
         end
         else if (byteSt && tick && ph_q == 2'd2)
         begin
            if (st_q == ST_RDDATA && bit_q < 4'd8)
               sh_q <= {sh_q[7:0], 1'b1};
         end
         else if (byteSt && bitEnd)
            sh_q <= (st_q == ST_RDDATA) ? sh_q : {sh_q[7:0], 1'b1};
         // receive: sample on clock high, msb first; ack bit inserted before slot 8
         if (st_q == ST_RDDATA && tick && ph_q == 2'd2 && bit_q < 4'd8 && sclSync)
         begin
            rdData <= {rdData[6:0], sdaSync}; // [RQ3]
            if (bit_q == 4'd7)
            begin
               rdValid <= 1'b1;
               sh_q <= {lastRd_q, 8'hFF}; // [RQ4] [RQ8]
            end
         end
      end
   end
   // transfer sequencing
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q <= ST_IDLE;
         rd_q <= 1'b0;
         lastRd_q <= 1'b0;
         dev_q <= 7'h00;
         badr_q <= 8'h00;
         err_q <= 1'b0;
         done <= 1'b0;
         nackErr <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         nackErr <= 1'b0;
         case (st_q)
            ST_IDLE:
               if (reqValid)
               begin
                  rd_q <= reqRead;
                  dev_q <= devAddr; // [RQ13]
                  badr_q <= byteAddr;
                  lastRd_q <= 1'b0;
                  err_q <= 1'b0;
                  st_q <= ST_START;
               end
            ST_START:
               if (bitEnd)
                  st_q <= ST_DEVADR;
            ST_RESTART:
               if (bitEnd)
                  st_q <= ST_DEVRD;
            ST_DEVADR, ST_BYTADR, ST_DEVRD, ST_WRDATA:
               if (tick && ph_q == 2'd2 && bit_q == 4'd8 && sclSync)
               begin
                  // sample the memory's answer, act on it when the slot ends
                  if (sdaSync)
                     err_q <= 1'b1; // [RQ5]
               end
               else if (bitEnd && bit_q == 4'd8)
               begin
                  if (wrReady)
                     lastRd_q <= wrLast; // [RQ6]
                  if (err_q || (st_q == ST_WRDATA && lastRd_q))
                     st_q <= ST_STOP; // [RQ7]
                  else if (st_q == ST_DEVADR)
                     st_q <= ST_BYTADR;
                  else if (st_q == ST_BYTADR)
                     st_q <= rd_q ? ST_RESTART : ST_WRDATA; // [RQ14]
                  else if (st_q == ST_DEVRD)
                  begin
                     lastRd_q <= rdLast; // [RQ6]
                     st_q <= ST_RDDATA;
                  end
               end
            ST_RDDATA:
               if (bitEnd && bit_q == 4'd8)
               begin
                  if (lastRd_q)
                     st_q <= ST_STOP; // [RQ8]
                  else
                     lastRd_q <= rdLast; // [RQ6]
               end
            ST_STOP:
               if (bitEnd)
               begin
                  st_q <= ST_IDLE;
                  done <= 1'b1;
                  nackErr <= err_q;
               end
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end
endmodule // ism_master
`default_nettype wire

// [ism_master_checker.sv]
// port assertions for the serial memory master
`timescale 1ns/1ps
`default_nettype none
module ism_master_checker (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic pushPull,
   input wire logic reqReady,
   input wire logic busy,
   input wire logic done,
   input wire logic nackErr,
   input wire logic rdValid,
   input wire logic wrReady,
   input wire logic sclOut,
   input wire logic sclOen,
   input wire logic sdaOut,
   input wire logic sdaOen
);
   logic opened_q;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   // set once the start condition of the running transfer went out
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         opened_q <= 1'b0;
      else
         opened_q <= busy && (opened_q || !sdaOen);
   end
   sequence s_sclHigh;
      sclOen || sclOut;
   endsequence
   sequence s_busFree;
      sdaOen && (sclOen || sclOut);
   endsequence
   sequence s_startHold;
      s_sclHigh ##1 s_sclHigh;
   endsequence
   property p_sdaOpen; !sdaOen |-> !sdaOut; endproperty
   property p_odScl; !pushPull && !sclOen |-> !sclOut; endproperty
   property p_idleFree; !busy |-> s_busFree; endproperty
   property p_noEarlyScl; busy && !opened_q |-> s_sclHigh; endproperty
   property p_startSda; $fell(sdaOen) && !opened_q |-> s_startHold; endproperty
   property p_stopEnd; done |-> s_busFree; endproperty
   property p_donePulse; done |=> !done; endproperty
   property p_nackDone; nackErr |-> done; endproperty
   property p_oneAtATime; reqReady |-> !busy; endproperty
   property p_dataBusy; rdValid || wrReady |-> busy; endproperty
   a_sdaOpen: assert property (p_sdaOpen) else $error("sda driven high");
   a_odScl: assert property (p_odScl) else $error("scl driven high in open-drain");
   a_idleFree: assert property (p_idleFree) else $error("lines held while idle");
   a_noEarlyScl: assert property (p_noEarlyScl) else $error("scl low before start");
   a_startSda: assert property (p_startSda) else $error("sda fell with scl low");
   a_stopEnd: assert property (p_stopEnd) else $error("no stop before done");
   a_donePulse: assert property (p_donePulse) else $error("done too long");
   a_nackDone: assert property (p_nackDone) else $error("nack flag without done");
   a_oneAtATime: assert property (p_oneAtATime) else $error("ready while busy");
   a_dataBusy: assert property (p_dataBusy) else $error("data strobe while idle");
endmodule // ism_master_checker
bind ism_master ism_master_checker chk (.clk_sys, .resetn, .pushPull, .reqReady, .busy, .done, .nackErr,
   .rdValid, .wrReady, .sclOut, .sclOen, .sdaOut, .sdaOen);
`default_nettype wire

// [ism_mem_model.sv]
// behavioural serial memory on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module ism_mem_model #(
   parameter logic [6:0] DEV = 7'h51
)(
   input wire logic scl,
   input wire logic sda,
   output logic sdaLow
);
   logic [7:0] mem [256];
   logic [7:0] sh, ptr, txb;
   logic [3:0] cnt;
   logic act = 1'b0, rdMode, tx = 1'b0, mAck;
   int idx, nAck = 0, nNack = 0;
   realtime t0, bitNs;
   initial sdaLow = 1'b0;
   // start and stop are sda edges while scl is high
   always @(negedge sda)
      if (scl)
      begin
         act = 1'b1;
         // the clock fall that closes the start wraps this to bit 0
         cnt = 4'hF;
         idx = 0;
         tx = 1'b0;
         sdaLow = 1'b0;
      end
   always @(posedge sda)
      if (scl)
         act = 1'b0;
   // sample on rising scl, msb first, ack slot last
   always @(posedge scl)
      if (act)
      begin
         if (cnt == 4'h0) t0 = $realtime;
         if (cnt == 4'h1) bitNs = $realtime - t0;
         if (cnt != 4'h8) sh = {sh[6:0], sda};
         else if (tx) mAck = !sda;
         if (cnt == 4'h8 && tx && mAck) nAck++;
         if (cnt == 4'h8 && tx && !mAck) nNack++;
      end
   // change sda only while scl is low; after the ack slot drive the next read bit or release
   always @(negedge scl)
      if (act)
      begin
         if (cnt == 4'h8)
         begin
            cnt = 4'h0;
            if (tx) ptr = ptr + 8'h01;
            tx = rdMode && (!tx || mAck);
            txb = mem[ptr];
            sdaLow = tx && !txb[7];
         end
         else if (cnt == 4'h7)
         begin
            cnt = 4'h8;
            sdaLow = !tx && (idx > 0 || sh[7:1] == DEV);
            if (!tx && idx == 0) rdMode = sh[0];
            if (!tx && idx == 1) ptr = sh;
            if (!tx && idx > 1) mem[ptr] = sh;
            if (!tx && idx > 1) ptr = ptr + 8'h01;
            idx++;
         end
         else
         begin
            cnt = cnt + 4'h1;
            sdaLow = tx && !txb[3'h7 - cnt[2:0]];
         end
      end
endmodule // ism_mem_model
`default_nettype wire

// [ism_master_tb.sv]
// testbench for the serial memory master
`timescale 1ns/1ps
`default_nettype none
module ism_master_tb;
   logic clk_sys = 1'b0, resetn = 1'b0, fastMode = 1'b0, pushPull = 1'b0, reqValid = 1'b0, reqRead = 1'b0;
   logic wrValid = 1'b0, wrLast = 1'b0, rdLast = 1'b0;
   logic [6:0] devAddr = 7'h51;
   logic [7:0] byteAddr = 8'h00, wrData = 8'h00, rdData;
   logic reqReady, wrReady, rdValid, done, nackErr, busy, sclOut, sclOen, sdaOut, sdaOen, sdaLow, sclW, sdaW;
   logic [7:0] q [5];
   int n = 0, wi = 0, ri = 0, bad_count = 0, n_compared = 0, ppHigh = 0, a0, b0;
   ism_master #(.STD_QTR(4), .FAST_QTR(3)) dut (.clk_sys, .resetn, .fastMode, .pushPull, .reqValid, .reqReady,
      .reqRead, .devAddr, .byteAddr, .wrValid, .wrReady, .wrData, .wrLast, .rdLast, .rdValid, .rdData, .done,
      .nackErr, .busy, .sclIn(sclW), .sclOut, .sclOen, .sdaIn(sdaW), .sdaOut, .sdaOen);
   ism_mem_model mdl (.scl(sclW), .sda(sdaW), .sdaLow);
   // wire levels with pull-ups on both lines
   assign sclW = sclOen ? 1'b1 : sclOut;
   assign sdaW = !((!sdaOen && !sdaOut) || sdaLow);
   always #2 clk_sys = !clk_sys;
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // feeds write bytes, checks read bytes, steers the last-byte flag
   always @(posedge clk_sys)
   begin
      if (rdValid) chk8("read byte", q[ri], rdData);
      if (rdValid) ri++;
      if (wrReady) wi++;
      if (!sclOen && sclOut) ppHigh++;
      #1;
      wrData = q[wi];
      wrLast = (wi == n - 1);
      rdLast = (ri >= n - 1);
   end
   // one transfer, bounded waits for acceptance and for done
   task automatic xfer(input logic rd, input logic [7:0] adr, input int cnt, input logic expNack);
      int k;
      @(posedge clk_sys);
      n = cnt;
      wi = 0;
      ri = 0;
      a0 = mdl.nAck;
      b0 = mdl.nNack;
      #1;
      reqRead = rd;
      byteAddr = adr;
      wrValid = !rd;
      reqValid = 1'b1;
      k = 0;
      do @(posedge clk_sys); while (!reqReady && ++k < 100);
      #1;
      reqValid = 1'b0;
      k = 0;
      do @(posedge clk_sys); while (done !== 1'b1 && ++k < 3000);
      if (k >= 3000)
      begin
         bad_count++;
         give_verdict();
      end
      chk8("nack flag", {7'h00, expNack}, {7'h00, nackErr});
      chk8("stop seen", 8'h00, {7'h00, mdl.act});
      if (!expNack) chk8("bytes moved", 8'(cnt), 8'(rd ? ri : wi));
      if (rd) chk8("acks", 8'(cnt - 1), 8'(mdl.nAck - a0));
      if (rd) chk8("nacks", 8'h01, 8'(mdl.nNack - b0));
   endtask
   task automatic t_write_multi;
      q = '{8'hA5, 8'h3C, 8'h0F, 8'h00, 8'h00};
      xfer(1'b0, 8'hFE, 3, 1'b0);
      chk8("mem FE", 8'hA5, mdl.mem[8'hFE]);
      chk8("mem 00", 8'h0F, mdl.mem[8'h00]);
      chk8("std bit ns", 8'h40, 8'(int'(mdl.bitNs)));
   endtask
   task automatic t_read_multi;
      xfer(1'b1, 8'hFE, 3, 1'b0);
   endtask
   task automatic t_fast_push;
      #1;
      fastMode = 1'b1;
      pushPull = 1'b1;
      q = '{8'h5A, 8'h00, 8'h00, 8'h00, 8'h00};
      xfer(1'b0, 8'h10, 1, 1'b0);
      chk8("fast bit ns", 8'h30, 8'(int'(mdl.bitNs)));
      chk8("scl driven high", 8'h01, {7'h00, ppHigh > 0});
      xfer(1'b1, 8'h10, 1, 1'b0);
   endtask
   task automatic t_wrong_device;
      #1;
      fastMode = 1'b0;
      pushPull = 1'b0;
      devAddr = 7'h22;
      xfer(1'b0, 8'h40, 2, 1'b1);
      #1;
      devAddr = 7'h51;
   endtask
   initial
   begin
      repeat (12) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      t_write_multi();
      t_read_multi();
      t_fast_push();
      t_wrong_device();
      give_verdict();
   end
endmodule // ism_master_tb
`default_nettype wire
